// *** bench/psr_host.sv ***
// Host link model that frames transactions toward the memory block.
module psr_host (
	output logic link_clk_o,
	output logic cs_n_o,
	output logic phase_clk_o,
	output logic [7:0] dq_o,
	output logic dq_en_o,
	output logic strobe_o,
	output logic strobe_en_o,
	input wire logic [7:0] dq_i,
	input wire logic dq_oe_i,
	input wire logic strobe_i,
	input wire logic strobe_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		link_clk_o = 1'h0;
		cs_n_o = 1'h1;
		phase_clk_o = 1'h0;
		dq_o = 8'h00;
		dq_en_o = 1'h0;
		strobe_o = 1'h0;
		strobe_en_o = 1'h0;
	end
	// One link period; the phase clock lags a quarter period and pulses only when ps is set.
	task automatic tick(input logic ps);
		#1.5 link_clk_o = 1'h1;
		#1.5 phase_clk_o = ps;
		#1.5 link_clk_o = 1'h0;
		#1.5 phase_clk_o = 1'h0;
	endtask : tick
	// Runs one frame and two idle clocks after deselect, then lets the clock stand still.
	task automatic frame(input logic [7:0] cmd, input int n, input logic [7:0] wd[16],
		input logic [15:0] mask, output logic [7:0] rd[16], output int ok);
		ok = 0;
		cs_n_o = 1'h0;
		dq_en_o = 1'h1;
		dq_o = cmd;
		tick(1'h0);
		for (int i = 0; i < 8; i++) begin
			ok += int'(strobe_oe_i === 1'h1 && strobe_i === 1'h1);
			tick(1'h0);
		end
		dq_en_o = !cmd[7];
		strobe_en_o = !cmd[7];
		for (int j = 0; j < n; j++) begin
			dq_o = wd[j];
			strobe_o = mask[j];
			rd[j] = (dq_oe_i === 1'h1) ? dq_i : 8'hEE;
			tick(cmd[7]);
			if (!cmd[7])
				ok += int'(strobe_oe_i === 1'h0);
		end
		cs_n_o = 1'h1;
		dq_en_o = 1'h0;
		strobe_en_o = 1'h0;
		tick(1'h0);
		tick(1'h0);
	endtask : frame
endmodule : psr_host

// *** bench/psram_reset_and_centered_strobe_tb.sv ***
// Testbench for the memory-side reset and centered read-strobe block.
module psram_reset_and_centered_strobe_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, reset_i, hw_reset_n_i, out_ready_i, tog;
	logic lck, cs_n, ps_clk, h_dq_en, h_st, h_st_en, dq_oe_o, st_o, st_oe_o, ready_o, out_valid_o;
	logic [7:0] h_dq, dq_o, out_data_o;
	wire logic [7:0] dq_w;
	wire logic st_w;
	logic [7:0] wd[16], rd[16];
	logic [7:0] got[$];
	int n_errors, compares, tgl, ok;
	assign dq_w = dq_oe_o ? dq_o : (h_dq_en ? h_dq : (8'hA5 ^ {8{tog}}));
	assign st_w = st_oe_o ? st_o : (h_st_en ? h_st : tog);
	psr_core uut (.clk_i(clk_i), .reset_i(reset_i), .hw_reset_n_i(hw_reset_n_i),
		.interface_clock_i(lck), .cs_n_i(cs_n), .phase_shifted_clock_i(ps_clk), .dq_i(dq_w),
		.dq_o(dq_o), .dq_oe_o(dq_oe_o), .read_write_strobe_i(st_w),
		.read_write_strobe_o(st_o), .read_write_strobe_oe_o(st_oe_o), .ready_o(ready_o),
		.out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i));
	psr_host host (.link_clk_o(lck), .cs_n_o(cs_n), .phase_clk_o(ps_clk), .dq_o(h_dq),
		.dq_en_o(h_dq_en), .strobe_o(h_st), .strobe_en_o(h_st_en), .dq_i(dq_w),
		.dq_oe_i(dq_oe_o), .strobe_i(st_o), .strobe_oe_i(st_oe_o));
	initial begin
		clk_i = 1'h0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		tog <= ~tog;
		if (out_valid_o === 1'h1 && out_ready_i === 1'h1)
			got.push_back(out_data_o);
	end
	always @(st_o)
		tgl++;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	// Holds the pin low while both link clocks run, then waits for init and its crossing.
	task automatic t_reset();
		repeat (6) @(posedge clk_i);
		reset_i <= 1'h0;
		repeat (4) host.tick(1'h1);
		check(dq_oe_o, 1'h0);
		check(st_oe_o, 1'h0);
		@(posedge clk_i);
		hw_reset_n_i <= 1'h1;
		for (int i = 0; i < 200 && ready_o !== 1'h1; i++)
			host.tick(1'h0);
		check(ready_o, 1'h1);
		repeat (2) host.tick(1'h0);
	endtask : t_reset
	// Wrapping write with one masked byte, then a read back with the phase clock.
	task automatic t_write_read();
		for (int j = 0; j < 16; j++)
			wd[j] = 8'h30 + 8'(j);
		got.delete();
		host.frame(8'h03, 16, wd, 16'h0004, rd, ok);
		check(ok, 24);
		repeat (40) @(posedge clk_i);
		check(got.size(), 15);
		for (int j = 0; j < 15; j++)
			check(got[j], wd[j < 2 ? j : j + 1]);
		tgl = 0;
		host.frame(8'h83, 16, wd, 16'h0000, rd, ok);
		check(ok, 8);
		for (int j = 0; j < 16; j++)
			if (j != 2)
				check(rd[j], wd[j]);
		check(tgl, 14);
		check(dq_oe_o, 1'h0);
		check(st_oe_o, 1'h0);
	endtask : t_write_read
	// Offers more bytes than the buffer holds with the sink stalled, then drains.
	task automatic t_fifo();
		for (int j = 0; j < 16; j++)
			wd[j] = 8'hC0 + 8'(j);
		got.delete();
		@(posedge clk_i);
		out_ready_i <= 1'h0;
		repeat (3) host.frame(8'h00, 16, wd, 16'h0000, rd, ok);
		repeat (20) @(posedge clk_i);
		check(got.size(), 0);
		out_ready_i <= 1'h1;
		repeat (100) @(posedge clk_i);
		check(got.size() >= 32 && got.size() <= 33, 1'h1);
		check(got[0], 8'hC0);
		check(got[17], 8'hC1);
	endtask : t_fifo
	initial begin
		reset_i = 1'h1;
		hw_reset_n_i = 1'h0;
		out_ready_i = 1'h1;
		tog = 1'h0;
		t_reset();
		t_write_read();
		t_fifo();
		print_verdict();
	end
	initial begin
		#50000;
		n_errors++;
		print_verdict();
	end
endmodule : psram_reset_and_centered_strobe_tb

// *** hdl/psr_core.sv ***
// Memory-side link logic: reset handling, latency strobe, centered read strobe.
`include "psr_map.svh"

// Overview of operation
// - Reset pin returning high runs self-initialization, then the device waits idle for a transaction.
// - While reset pin is low, strobe and eight data lines are released.
// - In read data phase the device drives the strobe, toggling with data bytes.
// - Only the doubled initial latency is used; single latency never applies.
// - Read strobe transitions are timed from the phase-shifted clock edges.
// - Phase-shifted clock is ignored during writes; host may park it.
// - At transaction start the device drives the strobe to flag extra latency.
// - During write data the strobe is a host byte mask; device does not drive it.
module psr_core import psr_pkg::*; #(
	parameter int LATENCY = 4,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic hw_reset_n_i,
	input wire logic interface_clock_i,
	input wire logic cs_n_i,
	input wire logic phase_shifted_clock_i,
	input wire logic [7:0] dq_i,
	output logic [7:0] dq_o,
	output logic dq_oe_o,
	input wire logic read_write_strobe_i,
	output logic read_write_strobe_o,
	output logic read_write_strobe_oe_o,
	output logic ready_o,
	output logic out_valid_o,
	output logic [7:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int INIT_CYC = (`PSR_INIT_NS * `PSR_CLK_MHZ + 999) / 1000;
	localparam int LAT_CYC = LATENCY * `PSR_LAT_FACTOR;
	localparam int AMSB = `PSR_ADDR_MSB;

	// System clock domain: reset pin synchroniser, init timer, stream output stage.
	logic hw_s1, hw_s2, rst_all, ready, next_ready;
	logic [7:0] init_cnt, next_init_cnt;
	logic [7:0] out_data, next_out_data;
	logic out_valid, next_out_valid;
	logic f_out_valid, f_out_ready;
	logic [7:0] f_out_data;

	assign rst_all = reset_i | ~hw_s2;

	always_comb begin
		next_init_cnt = init_cnt;
		next_ready = ready;
		if (rst_all) begin
			next_init_cnt = '0;
			next_ready = 1'b0;
		end else if (!ready) begin
			next_init_cnt = init_cnt + 8'h01;
			next_ready = (init_cnt == 8'(INIT_CYC - 1));
		end
	end

	always_comb begin
		f_out_ready = !out_valid || out_ready_i;
		next_out_valid = out_valid;
		next_out_data = out_data;
		if (rst_all) begin
			next_out_valid = 1'b0;
		end else if (f_out_ready) begin
			next_out_valid = f_out_valid;
			next_out_data = f_out_data;
		end
	end

	always_ff @(posedge clk_i) begin
		hw_s1 <= hw_reset_n_i;
		hw_s2 <= hw_s1;
		if (reset_i) begin
			init_cnt <= '0;
			ready <= 1'b0;
			out_valid <= 1'b0;
			out_data <= `PSR_DQ_RESET;
		end else begin
			init_cnt <= next_init_cnt;
			ready <= next_ready;
			out_valid <= next_out_valid;
			out_data <= next_out_data;
		end
	end

	assign ready_o = ready;
	assign out_valid_o = out_valid;
	assign out_data_o = out_data;

	// Link clock domain: transaction sequencer and byte store.
	logic lr_s1, lr_s2, lk_s1, lk_s2, link_rst, link_ready;
	psr_state_e state, next_state;
	logic [7:0] lat_cnt, next_lat_cnt;
	logic [AMSB:0] addr, next_addr;
	logic is_read, next_is_read;
	logic [7:0] dq, next_dq;
	logic dq_oe, next_dq_oe, strobe_oe, next_strobe_oe, rd_phase, next_rd_phase;
	logic [7:0] mem [2**(AMSB+1)];
	logic [7:0] next_mem [2**(AMSB+1)];
	logic f_in_valid, f_in_ready;

	assign link_rst = !lr_s2;
	assign link_ready = lk_s2;

	always_comb begin
		next_state = state;
		next_lat_cnt = lat_cnt;
		next_addr = addr;
		next_is_read = is_read;
		next_dq = dq;
		next_dq_oe = dq_oe;
		next_strobe_oe = strobe_oe;
		next_rd_phase = rd_phase;
		next_mem = mem;
		f_in_valid = 1'b0;
		if (link_rst || cs_n_i) begin
			next_state = PSR_IDLE;
			next_dq_oe = 1'b0;
			next_strobe_oe = 1'b0;
			next_rd_phase = 1'b0;
		end else begin
			case (state)
				PSR_IDLE: begin
					if (link_ready) begin
						next_is_read = dq_i[`PSR_CMD_READ_BIT];
						next_addr = dq_i[AMSB:0];
						next_lat_cnt = 8'(LAT_CYC - 1);
						next_strobe_oe = 1'b1;
						next_state = PSR_LAT;
					end
				end
				PSR_LAT: begin
					if (lat_cnt == 8'h00) begin
						if (is_read) begin
							next_state = PSR_RDATA;
							next_dq = mem[addr];
							next_dq_oe = 1'b1;
							next_rd_phase = 1'b1;
							next_addr = addr + 1'b1;
						end else begin
							next_state = PSR_WDATA;
							next_strobe_oe = 1'b0;
						end
					end else begin
						next_lat_cnt = lat_cnt - 8'h01;
					end
				end
				PSR_RDATA: begin
					next_dq = mem[addr];
					next_addr = addr + 1'b1;
				end
				PSR_WDATA: begin
					f_in_valid = !read_write_strobe_i;
					if (f_in_valid && f_in_ready) begin
						next_mem[addr] = dq_i;
					end
					next_addr = addr + 1'b1;
				end
				default: begin
					next_state = PSR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge interface_clock_i) begin
		lr_s1 <= hw_reset_n_i;
		lr_s2 <= lr_s1;
		lk_s1 <= ready;
		lk_s2 <= lk_s1;
		mem <= next_mem;
		if (link_rst) begin
			state <= PSR_IDLE;
			lat_cnt <= '0;
			addr <= '0;
			is_read <= 1'b0;
			dq <= `PSR_DQ_RESET;
			dq_oe <= 1'b0;
			strobe_oe <= 1'b0;
			rd_phase <= 1'b0;
		end else begin
			state <= next_state;
			lat_cnt <= next_lat_cnt;
			addr <= next_addr;
			is_read <= next_is_read;
			dq <= next_dq;
			dq_oe <= next_dq_oe;
			strobe_oe <= next_strobe_oe;
			rd_phase <= next_rd_phase;
		end
	end

	assign dq_o = dq;
	assign dq_oe_o = dq_oe;
	assign read_write_strobe_oe_o = strobe_oe;

	// Phase-shifted clock domain: the strobe level itself.
	logic pr_s1, pr_s2, pd_s1, pd_s2, strobe, next_strobe;

	always_comb begin
		if (!pr_s2 || !pd_s2) begin
			next_strobe = `PSR_STROBE_EXTRA_LAT;
		end else begin
			next_strobe = ~strobe;
		end
	end

	always_ff @(posedge phase_shifted_clock_i) begin
		pr_s1 <= hw_reset_n_i;
		pr_s2 <= pr_s1;
		pd_s1 <= rd_phase;
		pd_s2 <= pd_s1;
		strobe <= next_strobe;
	end

	assign read_write_strobe_o = strobe;

	psr_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.wr_clk_i(interface_clock_i),
		.wr_rst_i(link_rst),
		.in_valid_i(f_in_valid),
		.in_ready_o(f_in_ready),
		.in_data_i(dq_i),
		.rd_clk_i(clk_i),
		.rd_rst_i(rst_all),
		.out_valid_o(f_out_valid),
		.out_ready_i(f_out_ready),
		.out_data_o(f_out_data)
	);

	sequence s_start;
		state == PSR_IDLE && !cs_n_i && link_ready;
	endsequence

	a_init_ready_time: assert property (@(posedge clk_i) disable iff (rst_all)
		(!ready && init_cnt == 8'(INIT_CYC - 1)) |=> ready)
		else $error("ready not raised after init time");
	a_reset_hiz: assert property (@(posedge interface_clock_i)
		link_rst |=> !dq_oe && !strobe_oe)
		else $error("lines driven during reset");
	a_read_strobe_drive: assert property (@(posedge interface_clock_i) disable iff (link_rst)
		(state == PSR_RDATA && !cs_n_i) |=> strobe_oe && dq_oe)
		else $error("strobe not driven in read data");
	a_double_latency: assert property (@(posedge interface_clock_i) disable iff (link_rst)
		s_start |=> lat_cnt == 8'(LAT_CYC - 1))
		else $error("latency not doubled");
	a_phase_toggle: assert property (@(posedge phase_shifted_clock_i) disable iff (!pr_s2)
		pd_s2 |=> strobe != $past(strobe))
		else $error("strobe did not toggle on phase clock");
	a_write_idle_level: assert property (@(posedge phase_shifted_clock_i) disable iff (!pr_s2)
		!pd_s2 |=> strobe == `PSR_STROBE_EXTRA_LAT)
		else $error("strobe moved outside read data");
	a_start_drive: assert property (@(posedge interface_clock_i) disable iff (link_rst)
		s_start |=> strobe_oe ##1 (strobe_oe || cs_n_i))
		else $error("strobe not driven at start");
	a_write_mask_input: assert property (@(posedge interface_clock_i) disable iff (link_rst)
		state == PSR_WDATA |-> !strobe_oe)
		else $error("strobe driven during write data");
endmodule : psr_core

// *** hdl/psr_fifo.sv ***
// Dual-clock FIFO with gray-coded pointers and valid/ready on both sides.
module psr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic wr_clk_i,
	input wire logic wr_rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic rd_clk_i,
	input wire logic rd_rst_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [AW:0] wr_bin, next_wr_bin, wr_gray, rd_bin, next_rd_bin, rd_gray;
	logic [AW:0] rg_s1, rg_s2, wg_s1, wg_s2;
	logic [AW:0] full_cmp;

	// Full when the write pointer is one lap ahead of the synced read pointer.
	always_comb begin
		full_cmp = {~rg_s2[AW:AW-1], rg_s2[AW-2:0]};
		in_ready_o = (wr_gray != full_cmp);
		out_valid_o = (rd_gray != wg_s2);
		out_data_o = mem[rd_bin[AW-1:0]];
		next_mem = mem;
		next_wr_bin = wr_bin;
		next_rd_bin = rd_bin;
		if (in_valid_i && in_ready_o) begin
			next_mem[wr_bin[AW-1:0]] = in_data_i;
			next_wr_bin = wr_bin + 1'b1;
		end
		if (out_valid_o && out_ready_i) begin
			next_rd_bin = rd_bin + 1'b1;
		end
	end

	always_ff @(posedge wr_clk_i) begin
		mem <= next_mem;
		rg_s1 <= rd_gray;
		rg_s2 <= rg_s1;
		if (wr_rst_i) begin
			wr_bin <= '0;
			wr_gray <= '0;
		end else begin
			wr_bin <= next_wr_bin;
			wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
		end
	end

	always_ff @(posedge rd_clk_i) begin
		wg_s1 <= wr_gray;
		wg_s2 <= wg_s1;
		if (rd_rst_i) begin
			rd_bin <= '0;
			rd_gray <= '0;
		end else begin
			rd_bin <= next_rd_bin;
			rd_gray <= next_rd_bin ^ (next_rd_bin >> 1);
		end
	end
endmodule : psr_fifo

// *** hdl/psr_map.svh ***
// Constants for the memory-side reset and centered read-strobe block.
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH
`define PSR_CLK_MHZ 125
`define PSR_INIT_NS 150
`define PSR_LAT_FACTOR 2
`define PSR_CMD_READ_BIT 7
`define PSR_ADDR_MSB 3
`define PSR_STROBE_EXTRA_LAT 1'h1
`define PSR_DQ_RESET 8'h00
`endif

// *** hdl/psr_pkg.sv ***
// Types shared by the memory-side reset and centered read-strobe block.
package psr_pkg;
	typedef enum logic [1:0] {
		PSR_IDLE = 2'h0,
		PSR_LAT = 2'h1,
		PSR_RDATA = 2'h3,
		PSR_WDATA = 2'h2
	} psr_state_e;
endpackage : psr_pkg
